// [bench/rbs_link_props.sv]
// Concurrent checks on the link between the host end and the device end.
`timescale 1ns/100ps
`default_nettype none
module rbs_link_props #(
   parameter int BOOT_CYCLES = 64
) (
   // Clock and reset.
   input wire logic        CLK,
   input wire logic        RST,
   // Link signals.
   input wire logic        reset_n_o,
   input wire logic        reset_n_oe,
   input wire logic        reset_n_pin,
   input wire logic        pad_pu,
   input wire logic        pad_pd,
   input wire logic        irq_n,
   input wire logic        reg_req,
   input wire logic        reg_wr,
   input wire logic        reg_port,
   input wire logic [15:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic        reg_ack,
   input wire logic        reg_err
);
   default clocking cb @(posedge CLK);
   endclocking
   default disable iff (RST);
   // Counts cycles with the interrupt output high.
   int hi_cnt_r;
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         hi_cnt_r <= 0;
      end else begin
         hi_cnt_r <= irq_n ? hi_cnt_r + 1 : 0;
      end
   end
   a_ack_one_cycle: assert property (reg_ack |=> !reg_ack)
      else $error("ack longer than one cycle");
   a_ack_has_cause: assert property (reg_ack |-> $past(reg_req) && !$past(reg_ack))
      else $error("ack without request");
   a_req_released: assert property (reg_ack |=> !reg_req)
      else $error("request kept after ack");
   a_req_held: assert property (reg_req && !reg_ack |=> reg_req && $stable(reg_addr)
      && $stable(reg_wr) && $stable(reg_port) && $stable(reg_wdata))
      else $error("request changed before ack");
   a_pin_irq_high: assert property (!reset_n_pin [*8] |-> irq_n)
      else $error("boot flag set during pin reset");
   a_pin_pad_default: assert property (!reset_n_pin [*8] |-> pad_pu && !pad_pd)
      else $error("pad control not default in pin reset");
   a_keeper_holds: assert property ($fell(reset_n_oe) && pad_pu && pad_pd
      && $past(reset_n_o, 4) == $past(reset_n_o) |-> reset_n_pin == $past(reset_n_o))
      else $error("keeper lost pin level");
   a_soft_reboot: assert property (reg_ack && !reg_err && reg_wr
      && reg_addr == 16'h0000 |-> ##[0:2] irq_n [*8])
      else $error("soft reset did not rerun boot");
   a_boot_length: assert property ($fell(irq_n) |-> hi_cnt_r >= BOOT_CYCLES)
      else $error("boot finished too early");
   c_soft_reset: cover property (reg_ack && reg_wr && reg_addr == 16'h0000);
   c_refused: cover property (reg_ack && reg_err);
   c_keeper: cover property ($fell(reset_n_oe) && pad_pu && pad_pd);
   c_boot_done: cover property ($fell(irq_n));
endmodule : rbs_link_props
`default_nettype wire

// [bench/reset_boot_status_control_tb.sv]
// Self-checking testbench joining the host end and the device end.
`timescale 1ns/100ps
`default_nettype none
module reset_boot_status_control_tb import rbs_pkg::*;;
   localparam int          BOOT_N  = 64;
   localparam logic [15:0] ID_CODE = 16'h3c3c; // Arbitrary value.
   localparam logic [7:0]  SREV    = 8'h21;    // Arbitrary value.
   localparam logic [7:0]  DREV    = 8'h07;    // Arbitrary value.
   logic        clk = 1'b0;
   logic        rst = 1'b1;
   logic        ana_ok = 1'b0;
   logic        io_ok = 1'b0;
   logic        core_ok = 1'b0;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic        mdb_op = 1'b0;
   logic        mdb_done = 1'b0;
   logic [31:0] prdata;
   logic        pready, pslverr, mdb_req, seq_clr, fw_clr, core_rst;
   logic [15:0] gpio_oe, gpio_keep;
   logic [3:0]  test_pd;
   int          n_fail = 0;
   int          n_checks = 0;
   rbs_link_if lnk ();
   rbs_device #(.BOOT_CYCLES(BOOT_N), .DEV_ID(ID_CODE), .SIL_REV(SREV), .DRV_REV(DREV))
      u_rbs_device (.CLK(clk), .RST(rst), .ANALOG_SUPPLY_OK(ana_ok),
      .IO_SUPPLY_ONE_OK(io_ok), .CORE_SUPPLY_OK(core_ok), .GPIO_OE(gpio_oe),
      .GPIO_KEEPER_EN(gpio_keep), .TEST_PULLDOWN_EN(test_pd), .SEQ_MEM_CLR(seq_clr),
      .FW_MEM_CLR(fw_clr), .CORE_IN_RESET(core_rst), .LNK(lnk.dev));
   rbs_host u_rbs_host (.CLK(clk), .RST(rst), .PSEL(psel), .PENABLE(penable),
      .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
      .PSLVERR(pslverr), .MDB_OPERATIONAL(mdb_op), .MDB_RESET_REQ(mdb_req),
      .MDB_RESET_DONE(mdb_done), .LNK(lnk.host));
   rbs_link_props #(.BOOT_CYCLES(BOOT_N)) u_rbs_link_props (.CLK(clk), .RST(rst),
      .reset_n_o(lnk.reset_n_o), .reset_n_oe(lnk.reset_n_oe),
      .reset_n_pin(lnk.reset_n_pin), .pad_pu(lnk.pad_pu), .pad_pd(lnk.pad_pd),
      .irq_n(lnk.irq_n), .reg_req(lnk.reg_req), .reg_wr(lnk.reg_wr),
      .reg_port(lnk.reg_port), .reg_addr(lnk.reg_addr), .reg_wdata(lnk.reg_wdata),
      .reg_ack(lnk.reg_ack), .reg_err(lnk.reg_err));
   always #20 clk = ~clk;
   function automatic logic [15:0] f_bit(input int pos, input logic v);
      f_bit = 16'h0000;
      f_bit[pos] = v;
   endfunction : f_bit
   function automatic logic [16:0] f_pad_rst();
      f_pad_rst = {1'b0, f_bit(PAD_PU_BIT, PAD_PU_RST) | f_bit(PAD_PD_BIT, PAD_PD_RST)};
   endfunction : f_pad_rst
   function automatic logic [16:0] f_ident(input int k);
      f_ident = {1'b0, (k == 0) ? ID_CODE : {8'h00, (k == 1) ? SREV : DREV}};
   endfunction : f_ident
   task automatic summarize();
      $display("checks %0d mismatches %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : summarize
   task automatic chk_val(input logic [31:0] got, input logic [31:0] exp, input string m);
      n_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("MISMATCH t=%0t %s got %h exp %h", $time, m, got, exp);
      end
   endtask : chk_val
   task automatic chk_bit(input logic got, input logic exp, input string m);
      chk_val({31'h0, got}, {31'h0, exp}, m);
   endtask : chk_bit
   task automatic tmo();
      n_fail++;
      $display("MISMATCH t=%0t wait timed out", $time);
      summarize();
   endtask : tmo
   task automatic wait_irq(input logic lvl);
      int i;
      for (i = 0; i < 3000 && lnk.irq_n !== lvl; i++) @(posedge clk);
      if (lnk.irq_n !== lvl) tmo();
   endtask : wait_irq
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
      int i;
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      for (i = 0; i < 50; i++) begin
         @(posedge clk);
         if (pready === 1'b1) break;
      end
      if (pready !== 1'b1) tmo();
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic dev(input logic wr, input logic port, input logic [15:0] a,
                      input logic [15:0] d, output logic [15:0] q, output logic e);
      logic [31:0] s;
      logic        x;
      int          i;
      apb(1'b1, HREG_WDATA, {16'h0, d}, s, x);
      apb(1'b1, HREG_CMD, {14'h0, port, wr, a}, s, x);
      s = 32'h1;
      for (i = 0; i < 200 && s[0] !== 1'b0; i++) apb(1'b0, HREG_STAT, 32'h0, s, x);
      if (s[0] !== 1'b0) tmo();
      q = s[31:16];
      e = s[1];
   endtask : dev
   task automatic rd_chk(input logic port, input logic [15:0] a, input logic [16:0] exp);
      logic [15:0] q;
      logic        e;
      dev(1'b0, port, a, 16'h0, q, e);
      chk_val({15'h0, e, q}, {15'h0, exp}, "device read");
   endtask : rd_chk
   initial begin
      logic [15:0] q, g;
      logic        e;
      logic [31:0] s;
      int          k, i;
      g = 16'($urandom(40));
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      ana_ok <= 1'b1;
      io_ok <= 1'b1;
      repeat (20) @(posedge clk);
      chk_bit(core_rst & lnk.irq_n, 1'b1, "held without core supply");
      core_ok <= 1'b1;
      wait_irq(1'b0);
      chk_bit(core_rst, 1'b0, "core running");
      chk_val({28'h0, test_pd}, {28'h0, TEST_PD_ON}, "test pulldowns");
      for (k = 0; k < 3; k++) rd_chk(1'b0, k[15:0], f_ident(k));
      rd_chk(1'b0, ADDR_STAT_A, {1'b0, f_bit(BOOT_DONE_BIT, 1'b1)});
      rd_chk(1'b0, ADDR_STAT_B, {1'b0, f_bit(BOOT_DONE_BIT, 1'b1)});
      rd_chk(1'b0, ADDR_PAD, f_pad_rst());
      rd_chk(1'b0, 16'h0123, {1'b1, 16'h0000});
      apb(1'b0, 8'h40, 32'h0, s, e);
      chk_bit(e, 1'b1, "unmapped host register");
      $display("test power_up done");
      for (k = 0; k < 4; k++) begin
         g = (k == 0) ? 16'hffff : 16'($urandom);
         dev(1'b1, 1'b0, ADDR_GPIO_OE, g, q, e);
         chk_val({16'h0, gpio_keep}, {16'h0, ~g}, "keepers on inputs");
      end
      dev(1'b1, 1'b0, ADDR_IDENT, 16'($urandom), q, e);
      chk_bit(lnk.irq_n, 1'b1, "boot flags cleared");
      chk_val({16'h0, gpio_keep}, 32'h0000ffff, "pins back to inputs");
      chk_bit(seq_clr | fw_clr, 1'b0, "memories kept");
      dev(1'b0, 1'b1, ADDR_STAT_A, 16'h0, q, e);
      chk_bit(e, 1'b1, "other port refused");
      rd_chk(1'b0, ADDR_STAT_B, {1'b0, f_bit(BOOT_DONE_BIT, 1'b0)});
      dev(1'b1, 1'b0, ADDR_GPIO_OE, 16'h0001, q, e);
      chk_bit(lnk.irq_n, 1'b0, "write held until boot done");
      wait_irq(1'b0);
      rd_chk(1'b1, ADDR_SIREV, {9'h000, SREV});
      $display("test soft_reset done");
      dev(1'b1, 1'b0, ADDR_PAD, 16'h0003, q, e);
      apb(1'b1, HREG_CTRL, {16'h0, f_bit(CTRL_FLOAT_BIT, 1'b1)}, s, e);
      repeat (20) @(posedge clk);
      chk_bit(lnk.reset_n_pin & ~lnk.irq_n, 1'b1, "keeper holds pin");
      rd_chk(1'b0, ADDR_PAD, {1'b0, 16'h0003});
      apb(1'b1, HREG_CTRL, 32'h0, s, e);
      $display("test keeper done");
      dev(1'b1, 1'b0, ADDR_GPIO_OE, g, q, e);
      core_ok <= 1'b0;
      repeat (20) @(posedge clk);
      chk_bit(seq_clr & fw_clr, 1'b1, "memories cleared");
      chk_bit(core_rst & lnk.irq_n, 1'b1, "core held asleep");
      chk_val({16'h0, gpio_oe}, 32'h0, "pins reset asleep");
      core_ok <= 1'b1;
      wait_irq(1'b0);
      rd_chk(1'b0, ADDR_PAD, {1'b0, 16'h0003});
      $display("test sleep done");
      mdb_op <= 1'b1;
      apb(1'b1, HREG_CTRL, {16'h0, f_bit(CTRL_HWRST_BIT, 1'b1)}, s, e);
      for (i = 0; i < 50 && mdb_req !== 1'b1; i++) @(posedge clk);
      repeat (10) @(posedge clk);
      chk_bit(mdb_req & lnk.reset_n_pin, 1'b1, "pin waits for bus reset");
      mdb_done <= 1'b1;
      for (i = 0; i < 50 && lnk.reset_n_pin !== 1'b0; i++) @(posedge clk);
      mdb_done <= 1'b0;
      chk_bit(lnk.reset_n_pin, 1'b0, "pin driven low");
      wait_irq(1'b1);
      wait_irq(1'b0);
      rd_chk(1'b0, ADDR_PAD, f_pad_rst());
      $display("test pin_reset done");
      mdb_op <= 1'b0;
      for (k = 0; k < 2; k++) begin
         dev(1'b1, 1'b0, ADDR_PAD, 16'h0003, q, e);
         if (k == 0) ana_ok <= 1'b0;
         else io_ok <= 1'b0;
         repeat (10) @(posedge clk);
         ana_ok <= 1'b1;
         io_ok <= 1'b1;
         chk_bit(lnk.irq_n, 1'b1, "dropout resets");
         wait_irq(1'b0);
         rd_chk(1'b0, ADDR_PAD, f_pad_rst());
      end
      $display("test dropout done");
      summarize();
   end
endmodule : reset_boot_status_control_tb
`default_nettype wire

// [rtl/rbs_device.sv]
// Device end: power-on, pin, software and sleep resets, boot status and identity registers.
//
// Register access over APB was left to the implementer.
`timescale 1ns/100ps
`default_nettype none
module rbs_device import rbs_pkg::*; #(
   parameter int          NGPIO       = 16,
   parameter int          BOOT_CYCLES = BOOT_CYCLES_DEF,
   parameter logic [15:0] DEV_ID      = 16'h5a5a,
   parameter logic [7:0]  SIL_REV     = 8'h01,
   parameter logic [7:0]  DRV_REV     = 8'h01
) (
   // Clock and reset.
   input  wire logic             CLK,
   input  wire logic             RST,
   // Supply indications.
   input  wire logic             ANALOG_SUPPLY_OK,
   input  wire logic             IO_SUPPLY_ONE_OK,
   input  wire logic             CORE_SUPPLY_OK,
   // Digital pin states.
   output logic [NGPIO-1:0]      GPIO_OE,
   output logic [NGPIO-1:0]      GPIO_KEEPER_EN,
   output logic [3:0]            TEST_PULLDOWN_EN,
   // Memory and core status.
   output logic                  SEQ_MEM_CLR,
   output logic                  FW_MEM_CLR,
   output logic                  CORE_IN_RESET,
   // Link to the host.
   rbs_link_if.dev               LNK
);
   typedef struct packed {
      rbs_dev_state_t   st;
      logic [15:0]      cnt;
      logic             boot_done;
      logic             pu;
      logic             pd;
      logic [NGPIO-1:0] oe;
      logic             fail_next;
      logic             sr_port;
      logic             ack;
      logic             err;
      logic [15:0]      rdata;
      logic             seq_clr;
      logic             fw_clr;
      logic             keep_lvl;
      logic             powered;
   } rbs_dev_t;

   localparam rbs_dev_t DEV_RST = '{st: DS_POR, pu: PAD_PU_RST, pd: PAD_PD_RST,
                                   seq_clr: 1'b1, fw_clr: 1'b1, default: '0};

   rbs_dev_t   r_r;
   rbs_dev_t   r_nxt;
   logic [3:0] sync_q;
   logic       an_ok;
   logic       io_ok;
   logic       core_ok;
   logic       pin_s;
   logic       live;

   rbs_sync3 #(
      .W    (4),
      .INIT (4'h0)
   ) u_sync (
      .CLK (CLK),
      .RST (RST),
      .D   ({ANALOG_SUPPLY_OK, IO_SUPPLY_ONE_OK, CORE_SUPPLY_OK, LNK.reset_n_pin}),
      .Q   (sync_q)
   );

   assign {an_ok, io_ok, core_ok, pin_s} = sync_q;

   always_comb begin
      r_nxt          = r_r;
      live           = 1'b0;
      r_nxt.ack      = 1'b0;
      r_nxt.err      = 1'b0;
      r_nxt.seq_clr  = 1'b0;
      r_nxt.fw_clr   = 1'b0;
      r_nxt.keep_lvl = pin_s;
      if (!(an_ok && io_ok) || (!r_r.powered && !core_ok)) begin
         // Supplies missing or interrupted: everything back to power-on state.
         r_nxt          = DEV_RST;
         r_nxt.keep_lvl = pin_s;
      end else if (!core_ok) begin
         // Sleep: core and its registers in reset, pad control kept.
         r_nxt.st        = DS_SLEEP;
         r_nxt.cnt       = '0;
         r_nxt.boot_done = 1'b0;
         r_nxt.oe        = '0;
         r_nxt.fail_next = 1'b0;
         r_nxt.seq_clr   = 1'b1;
         r_nxt.fw_clr    = 1'b1;
      end else if (!pin_s) begin
         // Hardware reset: every register to default, boot waits for release.
         r_nxt          = DEV_RST;
         r_nxt.st       = DS_BOOT;
         r_nxt.powered  = 1'b1;
         r_nxt.keep_lvl = pin_s;
      end else begin
         live = 1'b1;
         case (r_r.st)
            DS_POR, DS_SLEEP: begin
               r_nxt.st      = DS_BOOT;
               r_nxt.cnt     = '0;
               r_nxt.powered = 1'b1;
            end
            DS_BOOT: begin
               r_nxt.cnt = r_r.cnt + 16'h0001;
               if (r_r.cnt == 16'(BOOT_CYCLES - 1)) begin
                  r_nxt.st        = DS_RUN;
                  r_nxt.boot_done = 1'b1;
               end
            end
            DS_RUN: begin
               r_nxt.st = DS_RUN;
            end
            default: begin
               r_nxt.st = DS_POR;
            end
         endcase
         if (LNK.reg_req && !r_r.ack) begin
            r_nxt.ack       = 1'b1;
            r_nxt.rdata     = '0;
            r_nxt.fail_next = 1'b0;
            if (r_r.fail_next && LNK.reg_port != r_r.sr_port) begin
               r_nxt.err = 1'b1;
            end else begin
               case (LNK.reg_addr)
                  ADDR_IDENT: begin
                     r_nxt.rdata = DEV_ID;
                     if (LNK.reg_wr) begin
                        // Software reset: pad control and memories survive.
                        r_nxt.oe        = '0;
                        r_nxt.boot_done = 1'b0;
                        r_nxt.st        = DS_BOOT;
                        r_nxt.cnt       = '0;
                        r_nxt.fail_next = 1'b1;
                        r_nxt.sr_port   = LNK.reg_port;
                     end
                  end
                  ADDR_SIREV: begin
                     r_nxt.rdata = {8'h00, SIL_REV};
                  end
                  ADDR_DRVREV: begin
                     r_nxt.rdata = {8'h00, DRV_REV};
                  end
                  ADDR_STAT_A, ADDR_STAT_B: begin
                     r_nxt.rdata[BOOT_DONE_BIT] = r_r.boot_done;
                  end
                  ADDR_PAD: begin
                     r_nxt.rdata[PAD_PU_BIT] = r_r.pu;
                     r_nxt.rdata[PAD_PD_BIT] = r_r.pd;
                     if (LNK.reg_wr) begin
                        r_nxt.pu = LNK.reg_wdata[PAD_PU_BIT];
                        r_nxt.pd = LNK.reg_wdata[PAD_PD_BIT];
                     end
                  end
                  ADDR_GPIO_OE: begin
                     r_nxt.rdata[NGPIO-1:0] = r_r.oe;
                     if (LNK.reg_wr) begin
                        r_nxt.oe = LNK.reg_wdata[NGPIO-1:0];
                     end
                  end
                  default: begin
                     r_nxt.err = 1'b1;
                  end
               endcase
            end
         end
      end
      if (!live && LNK.reg_req && !r_r.ack) begin
         r_nxt.ack   = 1'b1;
         r_nxt.err   = 1'b1;
         r_nxt.rdata = '0;
      end
   end

   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         r_r <= DEV_RST;
      end else begin
         r_r <= r_nxt;
      end
   end

   // Pin and status outputs.
   assign GPIO_OE          = r_r.oe;
   assign GPIO_KEEPER_EN   = ~r_r.oe;
   assign TEST_PULLDOWN_EN = TEST_PD_ON;
   assign SEQ_MEM_CLR      = r_r.seq_clr;
   assign FW_MEM_CLR       = r_r.fw_clr;
   assign CORE_IN_RESET    = ~(r_r.st == DS_BOOT || r_r.st == DS_RUN);
   assign LNK.irq_n        = ~r_r.boot_done;
   assign LNK.pad_pu       = r_r.pu;
   assign LNK.pad_pd       = r_r.pd;
   assign LNK.keep_lvl     = r_r.keep_lvl;
   assign LNK.reg_ack      = r_r.ack;
   assign LNK.reg_err      = r_r.err;
   assign LNK.reg_rdata    = r_r.rdata;
endmodule : rbs_device
`default_nettype wire

// [rtl/rbs_host.sv]
// Host end: APB command registers, reset pin sequencing and device register accesses.
`timescale 1ns/100ps
`default_nettype none
module rbs_host import rbs_pkg::*; #(
   parameter int RST_LOW = RST_LOW_CYCLES
) (
   // Clock and reset.
   input  wire logic        CLK,
   input  wire logic        RST,
   // APB slave.
   input  wire logic        PSEL,
   input  wire logic        PENABLE,
   input  wire logic        PWRITE,
   input  wire logic [7:0]  PADDR,
   input  wire logic [31:0] PWDATA,
   output logic [31:0]      PRDATA,
   output logic             PREADY,
   output logic             PSLVERR,
   // Multi-drop bus reset handshake.
   input  wire logic        MDB_OPERATIONAL,
   output logic             MDB_RESET_REQ,
   input  wire logic        MDB_RESET_DONE,
   // Link to the device.
   rbs_link_if.host         LNK
);
   typedef struct packed {
      rbs_host_state_t st;
      logic [15:0]     cnt;
      logic            flt;
      logic            pend;
      logic            req;
      logic            wr;
      logic            port;
      logic [15:0]     addr;
      logic [15:0]     wdata;
      logic [15:0]     rdata;
      logic            err;
      logic [31:0]     prdata;
      logic            pslverr;
   } rbs_host_s_t;

   localparam rbs_host_s_t HOST_RST = '{st: HS_IDLE, default: '0};

   rbs_host_s_t r_r;
   rbs_host_s_t r_nxt;
   logic        irq_s;
   logic        boot_ok;
   logic        busy;

   rbs_sync3 #(
      .W    (1),
      .INIT (1'b1)
   ) u_irq_sync (
      .CLK (CLK),
      .RST (RST),
      .D   (LNK.irq_n),
      .Q   (irq_s)
   );

   assign boot_ok = ~irq_s;
   assign busy    = r_r.pend | r_r.req;

   always_comb begin
      r_nxt = r_r;
      if (PSEL && !PENABLE) begin
         r_nxt.prdata  = '0;
         r_nxt.pslverr = 1'b0;
         case (PADDR)
            HREG_CTRL:  r_nxt.prdata[CTRL_FLOAT_BIT] = r_r.flt;
            HREG_CMD:   r_nxt.prdata[17:0] = {r_r.port, r_r.wr, r_r.addr};
            HREG_WDATA: r_nxt.prdata[15:0] = r_r.wdata;
            HREG_STAT:  r_nxt.prdata = {r_r.rdata, 12'h000, r_r.st != HS_IDLE, boot_ok,
                                        r_r.err, busy};
            default:    r_nxt.pslverr = 1'b1;
         endcase
         if (PWRITE && PADDR == HREG_CMD && busy) begin
            r_nxt.pslverr = 1'b1;
         end
      end
      if (PSEL && PENABLE && PWRITE) begin
         case (PADDR)
            HREG_CTRL: begin
               r_nxt.flt = PWDATA[CTRL_FLOAT_BIT];
               if (PWDATA[CTRL_HWRST_BIT] && r_r.st == HS_IDLE) begin
                  r_nxt.cnt = '0;
                  r_nxt.st  = MDB_OPERATIONAL ? HS_BUSRST : HS_PINLOW;
               end
            end
            HREG_CMD: begin
               if (!busy) begin
                  r_nxt.addr = PWDATA[15:0];
                  r_nxt.wr   = PWDATA[CMD_WR_BIT];
                  r_nxt.port = PWDATA[CMD_PORT_BIT];
                  r_nxt.pend = 1'b1;
                  r_nxt.err  = 1'b0;
               end
            end
            HREG_WDATA: r_nxt.wdata = busy ? r_r.wdata : PWDATA[15:0];
            default: r_nxt.wdata = r_r.wdata;
         endcase
      end
      case (r_r.st)
         HS_IDLE: r_nxt.cnt = '0;
         HS_BUSRST: begin
            if (MDB_RESET_DONE) begin
               r_nxt.st = HS_PINLOW;
            end
         end
         HS_PINLOW: begin
            r_nxt.cnt = r_r.cnt + 16'h0001;
            if (r_r.cnt == 16'(RST_LOW - 1)) begin
               r_nxt.st = HS_IDLE;
            end
         end
         default: r_nxt.st = HS_IDLE;
      endcase
      // Writes other than a software reset wait until boot completion is seen.
      if (r_r.pend && r_r.st == HS_IDLE && (boot_ok || !r_r.wr || r_r.addr == ADDR_IDENT)) begin
         r_nxt.pend = 1'b0;
         r_nxt.req  = 1'b1;
      end
      if (r_r.req && LNK.reg_ack) begin
         r_nxt.req   = 1'b0;
         r_nxt.rdata = LNK.reg_rdata;
         r_nxt.err   = LNK.reg_err;
      end
   end

   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         r_r <= HOST_RST;
      end else begin
         r_r <= r_nxt;
      end
   end

   assign PRDATA        = r_r.prdata;
   assign PSLVERR       = r_r.pslverr;
   assign PREADY        = 1'b1;
   assign MDB_RESET_REQ = (r_r.st == HS_BUSRST);
   assign LNK.reset_n_o  = (r_r.st != HS_PINLOW);
   assign LNK.reset_n_oe = (r_r.st == HS_PINLOW) | ~r_r.flt;
   assign LNK.reg_req    = r_r.req;
   assign LNK.reg_wr     = r_r.wr;
   assign LNK.reg_port   = r_r.port;
   assign LNK.reg_addr   = r_r.addr;
   assign LNK.reg_wdata  = r_r.wdata;
endmodule : rbs_host
`default_nettype wire

// [rtl/rbs_link_if.sv]
// Link between the host end and the device end: reset pin, interrupt pin, register port.
`timescale 1ns/100ps
`default_nettype none
interface rbs_link_if;
   logic        reset_n_o;
   logic        reset_n_oe;
   logic        pad_pu;
   logic        pad_pd;
   logic        keep_lvl;
   logic        reset_n_pin;
   logic        irq_n;
   logic        reg_req;
   logic        reg_wr;
   logic        reg_port;
   logic [15:0] reg_addr;
   logic [15:0] reg_wdata;
   logic        reg_ack;
   logic        reg_err;
   logic [15:0] reg_rdata;

   // Pin level: driver first, then keeper, pull-down, pull-up; an open pin reads high.
   assign reset_n_pin = reset_n_oe ? reset_n_o :
                        (pad_pu & pad_pd) ? keep_lvl :
                        pad_pd ? 1'b0 : 1'b1;

   modport dev (input reset_n_pin, reg_req, reg_wr, reg_port, reg_addr, reg_wdata,
                output pad_pu, pad_pd, keep_lvl, irq_n, reg_ack, reg_err, reg_rdata);
   modport host (output reset_n_o, reset_n_oe, reg_req, reg_wr, reg_port, reg_addr,
                 reg_wdata, input irq_n, reg_ack, reg_err, reg_rdata);
endinterface : rbs_link_if
`default_nettype wire

// [rtl/rbs_pkg.sv]
// Shared constants and types for the reset and boot status control block.
package rbs_pkg;
   // Device register offsets, one 16-bit register per offset.
   localparam logic [15:0] ADDR_IDENT   = 16'h0000;
   localparam logic [15:0] ADDR_SIREV   = 16'h0001;
   localparam logic [15:0] ADDR_DRVREV  = 16'h0002;
   localparam logic [15:0] ADDR_GPIO_OE = 16'h0700;
   localparam logic [15:0] ADDR_STAT_A  = 16'h1880;
   localparam logic [15:0] ADDR_STAT_B  = 16'h1980;
   localparam logic [15:0] ADDR_PAD     = 16'h1ad0;
   // Device field positions and reset values.
   localparam int          BOOT_DONE_BIT = 0;
   localparam int          PAD_PD_BIT    = 0;
   localparam int          PAD_PU_BIT    = 1;
   localparam logic        PAD_PU_RST    = 1'b1;
   localparam logic        PAD_PD_RST    = 1'b0;
   localparam logic [3:0]  TEST_PD_ON    = 4'hf;
   // Host register offsets on APB and their fields.
   localparam logic [7:0]  HREG_CTRL     = 8'h00;
   localparam logic [7:0]  HREG_CMD      = 8'h04;
   localparam logic [7:0]  HREG_WDATA    = 8'h08;
   localparam logic [7:0]  HREG_STAT     = 8'h0c;
   localparam int          CTRL_HWRST_BIT = 0;
   localparam int          CTRL_FLOAT_BIT = 1;
   localparam int          CMD_WR_BIT     = 16;
   localparam int          CMD_PORT_BIT   = 17;
   // Timing.
   localparam int          CLK_NS         = 40;
   localparam int          BOOT_CYCLES_DEF = 64;
   localparam int          RST_LOW_NS     = 1000;
   localparam int          RST_LOW_CYCLES = (RST_LOW_NS + CLK_NS - 1) / CLK_NS;
   // States.
   typedef enum logic [3:0] {
      DS_POR   = 4'b0001,
      DS_BOOT  = 4'b0010,
      DS_RUN   = 4'b0100,
      DS_SLEEP = 4'b1000
   } rbs_dev_state_t;
   typedef enum logic [2:0] {
      HS_IDLE   = 3'b001,
      HS_BUSRST = 3'b010,
      HS_PINLOW = 3'b100
   } rbs_host_state_t;
endpackage : rbs_pkg

// [rtl/rbs_sync3.sv]
// Three-stage input synchroniser whose output follows once stages two and three agree.
`timescale 1ns/100ps
`default_nettype none
module rbs_sync3 #(
   parameter int             W    = 1,
   parameter logic [W-1:0]   INIT = '0
) (
   // Clock and reset.
   input  wire logic         CLK,
   input  wire logic         RST,
   // Data.
   input  wire logic [W-1:0] D,
   output logic [W-1:0]      Q
);
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
      logic [W-1:0] s3;
      logic [W-1:0] q;
   } rbs_sync_t;

   rbs_sync_t r_r;
   rbs_sync_t r_nxt;

   always_comb begin
      r_nxt    = r_r;
      r_nxt.s1 = D;
      r_nxt.s2 = r_r.s1;
      r_nxt.s3 = r_r.s2;
      r_nxt.q  = (~(r_r.s2 ^ r_r.s3) & r_r.s3) | ((r_r.s2 ^ r_r.s3) & r_r.q);
   end

   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         r_r <= '{s1: INIT, s2: INIT, s3: INIT, q: INIT};
      end else begin
         r_r <= r_nxt;
      end
   end

   assign Q = r_r.q;
endmodule : rbs_sync3
`default_nettype wire
